// [rtl/adc_cfg_pkg.sv]
/*
  shared constants for the audio processing configuration register bank.
  assumes byte-wide registers on an 8-bit address control port.
*/
package adc_cfg_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] FILTER_VOLUME_CONFIG_ADDR = 8'h6c;
  localparam logic [7:0] AUTO_GAIN_CONFIG_ADDR = 8'h70;
  localparam logic [7:0] INPUT_CHANNEL_ENABLE_ADDR = 8'h73;
  localparam logic [7:0] OUTPUT_SLOT_ENABLE_ADDR = 8'h74;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FILTER_VOLUME_CONFIG_RST = 8'h40;
  localparam logic [7:0] AUTO_GAIN_CONFIG_RST = 8'he7;
  localparam logic [7:0] INPUT_CHANNEL_ENABLE_RST = 8'hf0;
  localparam logic [7:0] OUTPUT_SLOT_ENABLE_RST = 8'h00;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GANG_BIT = 7;
  localparam int BIQUAD_LSB = 5;
  localparam int SOFT_STEP_OFF_BIT = 4;
  localparam int AUTO_SEL_BIT = 3;
  localparam int LEVEL_LSB = 4;
  localparam int GAIN_LSB = 0;
  localparam int ANALOG_CHANNELS = 4;
  // ---------------------------------------------------------------
  // decoded value tables
  // ---------------------------------------------------------------
  localparam logic [7:0] LEVEL_BASE_DB = 8'h06;
  localparam logic [7:0] LEVEL_STEP_DB = 8'h02;
  localparam logic [7:0] GAIN_STEP_DB = 8'h03;
  localparam logic [3:0] GAIN_LAST_CODE = 4'hd;
endpackage

// [rtl/adc_cfg_store.sv]
/*
  small register store: four byte registers with registered read data.
  assumes the caller supplies a one-hot word select and a reset image parameter.
*/
module adc_cfg_store #(
  parameter int WORDS = 4,
  parameter logic [WORDS*8-1:0] RST_IMG = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WORDS-1:0] wsel,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic [WORDS-1:0] rsel,
  output logic [7:0] rdata_ff,
  output logic [WORDS*8-1:0] regs
);
  if (WORDS < 1) begin : g_bad_words
    $error("adc_cfg_store needs at least one word");
  end

  logic [7:0] word_ff [WORDS];
  logic [7:0] nxt_rdata;

  // ---------------------------------------------------------------
  // storage; the reset image is a parameter so reset loads only constants
  // ---------------------------------------------------------------
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        word_ff[i] <= RST_IMG[i*8 +: 8];
      end else if (wr && wsel[i]) begin
        word_ff[i] <= wdata;
      end
    end
    assign regs[i*8 +: 8] = word_ff[i];
  end

  always_comb begin
    nxt_rdata = 8'h00;
    for (int j = 0; j < WORDS; j++) begin
      if (rsel[j]) begin
        nxt_rdata = word_ff[j];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule // adc_cfg_store

// [rtl/adc_cfg_bank.sv]
/*
  configuration register bank for the multichannel audio processing path.
  assumes a synchronous byte-wide control port (address, write strobe,
  read strobe) already decoded from the serial control interface.
*/
module adc_cfg_bank #(
  parameter int CHANNELS = 8,
  parameter int VOL_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  input wire logic [CHANNELS*VOL_W-1:0] per_channel_volume,
  output logic [CHANNELS*VOL_W-1:0] digital_volume_ff,
  output logic [1:0] biquad_count_ff,
  output logic soft_step_off_ff,
  output logic automatic_gain_controller_ff,
  output logic [7:0] auto_level_target_db_ff,
  output logic [7:0] auto_level_gain_limit_db_ff,
  output logic gain_limit_reserved_ff,
  output logic [CHANNELS-1:0] analog_path_enable_ff,
  output logic [CHANNELS-1:0] pdm_path_enable_ff,
  output logic [CHANNELS-1:0] audio_serial_port_slot_oe_ff
);
  if (CHANNELS != 8 || VOL_W < 1) begin : g_bad_shape
    $error("adc_cfg_bank supports exactly eight channels");
  end

  localparam int NREG = 4;
  localparam int IX_FV = 0;
  localparam int IX_AG = 1;
  localparam int IX_IN = 2;
  localparam int IX_OS = 3;

  // ---------------------------------------------------------------
  // reset synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic [NREG-1:0] decode(input logic [7:0] a);
    logic [NREG-1:0] s;
    s = '0;
    s[IX_FV] = (a == adc_cfg_pkg::FILTER_VOLUME_CONFIG_ADDR);
    s[IX_AG] = (a == adc_cfg_pkg::AUTO_GAIN_CONFIG_ADDR);
    s[IX_IN] = (a == adc_cfg_pkg::INPUT_CHANNEL_ENABLE_ADDR);
    s[IX_OS] = (a == adc_cfg_pkg::OUTPUT_SLOT_ENABLE_ADDR);
    return s;
  endfunction

  logic [NREG-1:0] sel;
  logic [NREG*8-1:0] regs;
  logic [7:0] store_rdata;
  assign sel = decode(reg_addr);

  // unmapped addresses read zero because no select bit is set
  adc_cfg_store #(
    .WORDS(NREG),
    .RST_IMG({adc_cfg_pkg::OUTPUT_SLOT_ENABLE_RST, adc_cfg_pkg::INPUT_CHANNEL_ENABLE_RST,
      adc_cfg_pkg::AUTO_GAIN_CONFIG_RST, adc_cfg_pkg::FILTER_VOLUME_CONFIG_RST})
  ) u_store (
    .clk(clk),
    .rst_n(rst_n_ff),
    .wsel(sel),
    .wr(reg_wr),
    .wdata(reg_wdata),
    .rsel(sel),
    .rdata_ff(store_rdata),
    .regs(regs)
  );

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
    end
  end
  assign reg_rdata_ff = store_rdata;

  logic [7:0] fv;
  logic [7:0] ag;
  logic [7:0] inen;
  logic [7:0] osen;
  assign fv = regs[IX_FV*8 +: 8];
  assign ag = regs[IX_AG*8 +: 8];
  assign inen = regs[IX_IN*8 +: 8];
  assign osen = regs[IX_OS*8 +: 8];

  // ---------------------------------------------------------------
  // volume ganging and filter controls
  // ---------------------------------------------------------------
  // channel one's value is used even when channel one is disabled
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      digital_volume_ff <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        digital_volume_ff[c*VOL_W +: VOL_W] <= fv[adc_cfg_pkg::GANG_BIT] ?
          per_channel_volume[0 +: VOL_W] : per_channel_volume[c*VOL_W +: VOL_W];
      end
    end
  end

  localparam logic [1:0] BIQUAD_RST =
    adc_cfg_pkg::FILTER_VOLUME_CONFIG_RST[adc_cfg_pkg::BIQUAD_LSB +: 2];
  localparam logic SOFT_OFF_RST =
    adc_cfg_pkg::FILTER_VOLUME_CONFIG_RST[adc_cfg_pkg::SOFT_STEP_OFF_BIT];
  localparam logic AUTO_SEL_RST =
    adc_cfg_pkg::FILTER_VOLUME_CONFIG_RST[adc_cfg_pkg::AUTO_SEL_BIT];

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      biquad_count_ff <= BIQUAD_RST;
    end else begin
      biquad_count_ff <= fv[adc_cfg_pkg::BIQUAD_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      soft_step_off_ff <= SOFT_OFF_RST;
    end else begin
      soft_step_off_ff <= fv[adc_cfg_pkg::SOFT_STEP_OFF_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      automatic_gain_controller_ff <= AUTO_SEL_RST;
    end else begin
      automatic_gain_controller_ff <= fv[adc_cfg_pkg::AUTO_SEL_BIT];
    end
  end

  // ---------------------------------------------------------------
  // automatic gain level and limit decode
  // ---------------------------------------------------------------
  // magnitudes in dB: target is negative, so it is reported as attenuation
  logic [3:0] lvl_code;
  logic [3:0] gain_code;
  assign lvl_code = ag[adc_cfg_pkg::LEVEL_LSB +: 4];
  assign gain_code = ag[adc_cfg_pkg::GAIN_LSB +: 4];

  // linear in the code, so undocumented middle codes follow the end points
  function automatic logic [7:0] db_value(input logic [3:0] code, input logic [7:0] base,
    input logic [7:0] step);
    return base + 8'(step * {4'h0, code});
  endfunction

  localparam logic [7:0] LEVEL_RST_DB = db_value(
    adc_cfg_pkg::AUTO_GAIN_CONFIG_RST[adc_cfg_pkg::LEVEL_LSB +: 4],
    adc_cfg_pkg::LEVEL_BASE_DB, adc_cfg_pkg::LEVEL_STEP_DB);
  localparam logic [7:0] GAIN_RST_DB = db_value(
    adc_cfg_pkg::AUTO_GAIN_CONFIG_RST[adc_cfg_pkg::GAIN_LSB +: 4],
    adc_cfg_pkg::GAIN_STEP_DB, adc_cfg_pkg::GAIN_STEP_DB);
  localparam logic GAIN_RSVD_RST =
    adc_cfg_pkg::AUTO_GAIN_CONFIG_RST[adc_cfg_pkg::GAIN_LSB +: 4] > adc_cfg_pkg::GAIN_LAST_CODE;

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      auto_level_target_db_ff <= LEVEL_RST_DB;
    end else begin
      auto_level_target_db_ff <= db_value(lvl_code, adc_cfg_pkg::LEVEL_BASE_DB,
        adc_cfg_pkg::LEVEL_STEP_DB);
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      auto_level_gain_limit_db_ff <= GAIN_RST_DB;
    end else begin
      auto_level_gain_limit_db_ff <= db_value(gain_code, adc_cfg_pkg::GAIN_STEP_DB,
        adc_cfg_pkg::GAIN_STEP_DB);
    end
  end

  // reserved codes still decode linearly; the flag lets the user see them
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      gain_limit_reserved_ff <= GAIN_RSVD_RST;
    end else begin
      gain_limit_reserved_ff <= (gain_code > adc_cfg_pkg::GAIN_LAST_CODE);
    end
  end

  // ---------------------------------------------------------------
  // channel enables and output slots
  // ---------------------------------------------------------------
  // bit 7 is channel one, so index c maps to bit CHANNELS-1-c
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      analog_path_enable_ff <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        analog_path_enable_ff[c] <= (c < adc_cfg_pkg::ANALOG_CHANNELS) &&
          inen[CHANNELS-1-c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pdm_path_enable_ff <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        pdm_path_enable_ff[c] <= inen[CHANNELS-1-c];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      audio_serial_port_slot_oe_ff <= '0;
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        audio_serial_port_slot_oe_ff[c] <= osen[CHANNELS-1-c];
      end
    end
  end
endmodule // adc_cfg_bank

// [bench/adc_cfg_bank_sva.sv]
/* port checker for the configuration bank.
   assumes writes start only after the internal reset release. */
module adc_cfg_bank_sva #(
  parameter int CHANNELS = 8,
  parameter int VOL_W = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rvalid_ff,
  input wire logic [CHANNELS*VOL_W-1:0] per_channel_volume,
  input wire logic [CHANNELS*VOL_W-1:0] digital_volume_ff,
  input wire logic [1:0] biquad_count_ff,
  input wire logic soft_step_off_ff,
  input wire logic automatic_gain_controller_ff,
  input wire logic [7:0] auto_level_target_db_ff,
  input wire logic [7:0] auto_level_gain_limit_db_ff,
  input wire logic gain_limit_reserved_ff,
  input wire logic [CHANNELS-1:0] analog_path_enable_ff,
  input wire logic [CHANNELS-1:0] pdm_path_enable_ff,
  input wire logic [CHANNELS-1:0] audio_serial_port_slot_oe_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  function automatic logic [7:0] rev(logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  sequence s_wr(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  // own copy of the gang bit, so a stuck register still shows
  logic gang_ff;
  logic s_wr_hit;
  assign s_wr_hit = reg_wr && reg_addr == adc_cfg_pkg::FILTER_VOLUME_CONFIG_ADDR;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gang_ff <= 1'b0;
    end else if (s_wr_hit) begin
      gang_ff <= reg_wdata[adc_cfg_pkg::GANG_BIT];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  AST_CFG1: assert property (s_wr(adc_cfg_pkg::FILTER_VOLUME_CONFIG_ADDR) |-> ##2
    {biquad_count_ff, soft_step_off_ff, automatic_gain_controller_ff}
    == $past(reg_wdata[6:3], 2)) else $error("filter fields wrong");
  AST_LEVEL: assert property (s_wr(adc_cfg_pkg::AUTO_GAIN_CONFIG_ADDR) |-> ##2
    auto_level_target_db_ff == 8'h06 + 8'h02 * $past(reg_wdata[7:4], 2))
    else $error("target level wrong");
  AST_GAIN: assert property (s_wr(adc_cfg_pkg::AUTO_GAIN_CONFIG_ADDR) |-> ##2
    auto_level_gain_limit_db_ff == 8'h03 + 8'h03 * $past(reg_wdata[3:0], 2))
    else $error("gain limit wrong");
  AST_RSVD: assert property (s_wr(adc_cfg_pkg::AUTO_GAIN_CONFIG_ADDR) |-> ##2
    gain_limit_reserved_ff == ($past(reg_wdata[3:0], 2) > 4'hd)) else $error("reserved flag");
  AST_ANALOG: assert property (s_wr(adc_cfg_pkg::INPUT_CHANNEL_ENABLE_ADDR) |-> ##2
    analog_path_enable_ff == (rev($past(reg_wdata, 2)) & 8'h0f)) else $error("analog enables");
  AST_PDM: assert property (s_wr(adc_cfg_pkg::INPUT_CHANNEL_ENABLE_ADDR) |-> ##2
    pdm_path_enable_ff == rev($past(reg_wdata, 2))) else $error("pdm enables");
  AST_SLOT: assert property (s_wr(adc_cfg_pkg::OUTPUT_SLOT_ENABLE_ADDR) |-> ##2
    audio_serial_port_slot_oe_ff == rev($past(reg_wdata, 2))) else $error("slot enables");
  AST_RVALID: assert property (reg_rd |=> reg_rvalid_ff) else $error("no read answer");
  AST_PULSE: assert property (reg_rvalid_ff |-> $past(reg_rd)) else $error("stray answer");
  AST_GANG: assert property ((gang_ff && $stable(per_channel_volume)) [*3] |->
    digital_volume_ff[CHANNELS*VOL_W-1-:VOL_W] == per_channel_volume[VOL_W-1:0])
    else $error("gang volume wrong");
endmodule // adc_cfg_bank_sva

bind adc_cfg_bank adc_cfg_bank_sva #(.CHANNELS(CHANNELS), .VOL_W(VOL_W)) u_sva (
  .clk(clk),
  .arst_n(arst_n),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rvalid_ff(reg_rvalid_ff),
  .per_channel_volume(per_channel_volume),
  .digital_volume_ff(digital_volume_ff),
  .biquad_count_ff(biquad_count_ff),
  .soft_step_off_ff(soft_step_off_ff),
  .automatic_gain_controller_ff(automatic_gain_controller_ff),
  .auto_level_target_db_ff(auto_level_target_db_ff),
  .auto_level_gain_limit_db_ff(auto_level_gain_limit_db_ff),
  .gain_limit_reserved_ff(gain_limit_reserved_ff),
  .analog_path_enable_ff(analog_path_enable_ff),
  .pdm_path_enable_ff(pdm_path_enable_ff),
  .audio_serial_port_slot_oe_ff(audio_serial_port_slot_oe_ff)
);

// [bench/adc_cfg_host.sv]
/* host model on the byte control port of the bank.
   assumes strobes are sampled on the rising edge of clk. */
module adc_cfg_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic reg_rvalid_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 18'h0;
  // write then read back at once, or read alone; q stays x on timeout
  task automatic xfer(input logic [7:0] a, d, input logic w, output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    if (w) begin
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
    end
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wdata <= ~d;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (reg_rvalid_ff === 1'b1) begin
        q = reg_rdata_ff;
        break;
      end
    end
  endtask
endmodule // adc_cfg_host

// [bench/tb.sv]
/* self-checking bench for the configuration bank.
   assumes the host model and the bound checker sit beside it. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, reg_wr, reg_rd, reg_rvalid_ff, soft_step_off_ff;
  logic automatic_gain_controller_ff, gain_limit_reserved_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, q;
  logic [7:0] auto_level_target_db_ff, auto_level_gain_limit_db_ff;
  logic [7:0] analog_path_enable_ff, pdm_path_enable_ff, audio_serial_port_slot_oe_ff;
  logic [63:0] per_channel_volume, digital_volume_ff;
  logic [1:0] biquad_count_ff;
  int miscompares = 0;
  int cmp_count = 0;
  // address, data, write, expected read back
  logic [27:0] rows [12] = '{28'h6c_00_0_40, 28'h70_00_0_e7, 28'h73_00_0_f0, 28'h74_00_0_00,
    28'h6cf_f_1_ff, 28'h6c2_7_1_27, 28'h700_0_1_00, 28'h70f_d_1_fd, 28'h701_e_1_1e,
    28'h730_f_1_0f, 28'h74c_1_1_c1, 28'h55f_f_1_00};
  adc_cfg_bank u_dut (
    .clk(clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff),
    .per_channel_volume(per_channel_volume),
    .digital_volume_ff(digital_volume_ff),
    .biquad_count_ff(biquad_count_ff),
    .soft_step_off_ff(soft_step_off_ff),
    .automatic_gain_controller_ff(automatic_gain_controller_ff),
    .auto_level_target_db_ff(auto_level_target_db_ff),
    .auto_level_gain_limit_db_ff(auto_level_gain_limit_db_ff),
    .gain_limit_reserved_ff(gain_limit_reserved_ff),
    .analog_path_enable_ff(analog_path_enable_ff),
    .pdm_path_enable_ff(pdm_path_enable_ff),
    .audio_serial_port_slot_oe_ff(audio_serial_port_slot_oe_ff)
  );
  adc_cfg_host u_host (
    .clk(clk),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff)
  );
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic x(input logic [7:0] a, d, input logic w, input logic [7:0] exp);
    u_host.xfer(a, d, w, q);
    chk(q, exp);
    if ($isunknown(q)) complete_run();
  endtask
  task automatic rst_seq();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    arst_n = 1'b0;
    per_channel_volume = 64'h8877665544332211;
    rst_seq();
    chk({biquad_count_ff, auto_level_target_db_ff, auto_level_gain_limit_db_ff}, 18'h22218);
    chk({analog_path_enable_ff, pdm_path_enable_ff, audio_serial_port_slot_oe_ff,
      soft_step_off_ff, automatic_gain_controller_ff}, 26'h03c3c00);
    foreach (rows[i]) x(rows[i][27:20], rows[i][19:12], rows[i][8], rows[i][7:0]);
    chk({auto_level_target_db_ff, auto_level_gain_limit_db_ff, gain_limit_reserved_ff},
      17'h0105b);
    chk({biquad_count_ff, soft_step_off_ff, automatic_gain_controller_ff}, 4'h4);
    chk({analog_path_enable_ff, pdm_path_enable_ff}, 16'h00f0);
    chk(audio_serial_port_slot_oe_ff, 8'h83);
    x(8'h73, 8'h70, 1'b1, 8'h70);
    chk({analog_path_enable_ff, pdm_path_enable_ff}, 16'h0e0e);
    x(8'h6c, 8'h80, 1'b1, 8'h80);
    chk(digital_volume_ff, {8{8'h11}});
    x(8'h6c, 8'h00, 1'b1, 8'h00);
    chk(digital_volume_ff, per_channel_volume);
    rst_seq();
    chk({biquad_count_ff, auto_level_target_db_ff, auto_level_gain_limit_db_ff,
      audio_serial_port_slot_oe_ff}, 26'h2221800);
    x(8'h70, 8'h00, 1'b0, 8'he7);
    complete_run();
  end
endmodule // tb
